// [pkg/diff_enc_pkg.sv]
// Constants and types shared by the differential symbol encoder
`default_nettype none
package diff_enc_pkg;

    localparam int DATA_W     = 8;
    localparam int IQ_W       = 16;
    localparam int OFS_W      = 8;
    localparam int NST_W      = 9;
    localparam int CNT_W      = 4;
    localparam int MAP_DEPTH  = 256;
    localparam int SUM_W      = 17;

    // Q2.14 levels for the default 4-state constellation
    localparam logic [IQ_W-1:0] LEVEL_POS = 16'h4000;
    localparam logic [IQ_W-1:0] LEVEL_NEG = 16'hc000;
    localparam logic [IQ_W-1:0] LEVEL_ZERO = 16'h0000;

    localparam logic [NST_W-1:0] NUM_STATES_RST = 9'h004;
    localparam logic [DATA_W-1:0] PTR_RST       = 8'h00;

    // Bias of 128 * N keeps the pointer sum positive for any signed offset
    localparam logic [SUM_W-1:0] WRAP_BIAS_MUL = 17'h00080;

    typedef enum logic [1:0] {
        ENC_OFF,
        ENC_SYMBOL_OFFSET,
        ENC_DIFF_DATA
    } enc_mode_t;

endpackage

`default_nettype wire

// [rtl/differential_symbol_encoder.sv]
// Differential symbol encoder: symbol-offset and differential data modes
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Symbol-offset mode sends each value as a state movement, not a fixed point.
// - Offset mode works for any loaded map, one offset entry per data value.
// - Each symbol looks up its offset and moves the pointer by that signed amount.
// - An offset of +1 advances the pointer exactly one map position forward.
// - Offsets may be negative, zero or larger than one in magnitude.
// - Bits per symbol is ceil(log2(number of states)), but never below one or above eight.
// - Output state depends on prior pointer; pointer starts at map entry zero.
// - Equal data values always give the same movement anywhere in the stream.
// - In differential data mode the encoded bits are grouped into consecutive symbols, each emitted as its state, not a movement, in order.
// - Default 4-state map uses only the levels +1.0 and -1.0 on I and Q.
// - Differential data bit is current XOR previous raw bit, before I/Q mapping.
// - A raw bit change emits one; equal consecutive bits emit zero.
// - One output bit per adjacent input pair, so 14 bits in give 13 out.
module differential_symbol_encoder
    import diff_enc_pkg::*;
(
    input  wire logic                     sys_clk,
    input  wire logic                     arst_n,
    input  wire enc_mode_t                enc_mode,
    input  wire logic [NST_W-1:0]         num_states,
    input  wire logic                     enc_restart,
    input  wire logic                     ofs_wr,
    input  wire logic [DATA_W-1:0]        ofs_addr,
    input  wire logic signed [OFS_W-1:0]  ofs_val,
    input  wire logic                     map_wr,
    input  wire logic [DATA_W-1:0]        map_addr,
    input  wire logic [IQ_W-1:0]          map_i,
    input  wire logic [IQ_W-1:0]          map_q,
    input  wire logic                     in_valid,
    input  wire logic [DATA_W-1:0]        in_data,
    output logic                          out_valid,
    output logic [DATA_W-1:0]             out_state,
    output logic [IQ_W-1:0]               out_i,
    output logic [IQ_W-1:0]               out_q,
    output logic [CNT_W-1:0]              bits_per_symbol
);

    logic signed [OFS_W-1:0] ofs_tab_q [MAP_DEPTH];
    logic signed [OFS_W-1:0] ofs_tab_d [MAP_DEPTH];
    logic [IQ_W-1:0]         map_i_q   [MAP_DEPTH];
    logic [IQ_W-1:0]         map_i_d   [MAP_DEPTH];
    logic [IQ_W-1:0]         map_q_q   [MAP_DEPTH];
    logic [IQ_W-1:0]         map_q_d   [MAP_DEPTH];

    logic [DATA_W-1:0]       ptr_q,       ptr_d;
    logic                    prev_bit_q,  prev_bit_d;
    logic                    have_prev_q, have_prev_d;
    logic [DATA_W-1:0]       acc_q,       acc_d;
    logic [CNT_W-1:0]        acc_cnt_q,   acc_cnt_d;
    logic                    out_valid_q, out_valid_d;
    logic [DATA_W-1:0]       out_state_q, out_state_d;
    logic [IQ_W-1:0]         out_i_q,     out_i_d;
    logic [IQ_W-1:0]         out_q_q,     out_q_d;
    logic [CNT_W-1:0]        bps_q,       bps_d;

    logic [NST_W-1:0]        n_eff;
    logic [SUM_W-1:0]        ptr_sum;
    logic [SUM_W-1:0]        ptr_wrap;
    logic [DATA_W-1:0]       ptr_next;
    logic                    enc_bit;
    logic [DATA_W-1:0]       acc_shift;

    // Ceiling of log2, from one bit up to eight, so a one-state map still moves data
    function automatic logic [CNT_W-1:0] clog2_min1(input logic [NST_W-1:0] n);
        logic [CNT_W-1:0] b;
        b = 4'h1;
        for (int k = 1; k <= DATA_W; k++) begin
            if (n > (NST_W'(1) << (k - 1))) begin
                b = CNT_W'(k);
            end
        end
        return b;
    endfunction

    always_comb begin
        n_eff     = (num_states == 9'h000) ? 9'h001 : num_states;
        // Bias avoids a signed modulo; any offset wraps in one step
        ptr_sum   = SUM_W'(ptr_q) + SUM_W'(n_eff) * WRAP_BIAS_MUL
                    + SUM_W'(signed'(ofs_tab_q[in_data]));
        ptr_wrap  = ptr_sum % SUM_W'(n_eff);
        ptr_next  = ptr_wrap[DATA_W-1:0];
        enc_bit   = in_data[0] ^ prev_bit_q;
        acc_shift = {acc_q[DATA_W-2:0], enc_bit};
    end

    // Tables live in flops so any entry is read in the arrival cycle of its symbol
    // A write lands one cycle later; a lookup in the same cycle sees the old entry
    always_comb begin
        ofs_tab_d = ofs_tab_q;
        map_i_d   = map_i_q;
        map_q_d   = map_q_q;
        if (ofs_wr) begin
            ofs_tab_d[ofs_addr] = ofs_val;
        end
        if (map_wr) begin
            map_i_d[map_addr] = map_i;
            map_q_d[map_addr] = map_q;
        end
    end

    always_comb begin
        ptr_d       = ptr_q;
        prev_bit_d  = prev_bit_q;
        have_prev_d = have_prev_q;
        acc_d       = acc_q;
        acc_cnt_d   = acc_cnt_q;
        out_valid_d = 1'b0;
        out_state_d = out_state_q;
        out_i_d     = out_i_q;
        out_q_d     = out_q_q;
        // Follows num_states one cycle late, so hold it steady around a stream
        bps_d       = clog2_min1(n_eff);
        if (enc_restart) begin
            ptr_d       = PTR_RST;
            have_prev_d = 1'b0;
            acc_cnt_d   = '0;
            acc_d       = '0;
        end else if (in_valid) begin
            case (enc_mode)
                ENC_SYMBOL_OFFSET: begin
                    // Emitted state is where the pointer lands, never the data itself
                    ptr_d       = ptr_next;
                    out_valid_d = 1'b1;
                    out_state_d = ptr_next;
                    out_i_d     = map_i_q[ptr_next];
                    out_q_d     = map_q_q[ptr_next];
                end
                ENC_DIFF_DATA: begin
                    // Mode changes keep the bit history; only restart clears it
                    prev_bit_d  = in_data[0];
                    have_prev_d = 1'b1;
                    // The first raw bit only primes the history
                    if (have_prev_q) begin
                        if (acc_cnt_q + 4'h1 >= bps_q) begin
                            acc_cnt_d   = '0;
                            acc_d       = '0;
                            out_valid_d = 1'b1;
                            out_state_d = acc_shift;
                            out_i_d     = map_i_q[acc_shift];
                            out_q_d     = map_q_q[acc_shift];
                        end else begin
                            // A partial group waits for more bits
                            acc_cnt_d = acc_cnt_q + 4'h1;
                            acc_d     = acc_shift;
                        end
                    end
                end
                ENC_OFF: begin
                    out_valid_d = 1'b1;
                    out_state_d = in_data;
                    out_i_d     = map_i_q[in_data];
                    out_q_d     = map_q_q[in_data];
                end
                default: begin
                    out_valid_d = 1'b0;
                end
            endcase
        end
    end

    // Reset loads the default 4-state map; all other entries read as zero
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int k = 0; k < MAP_DEPTH; k++) begin
                ofs_tab_q[k] <= '0;
                map_i_q[k]   <= LEVEL_ZERO;
                map_q_q[k]   <= LEVEL_ZERO;
            end
            map_i_q[0] <= LEVEL_POS;
            map_q_q[0] <= LEVEL_POS;
            map_i_q[1] <= LEVEL_NEG;
            map_q_q[1] <= LEVEL_POS;
            map_i_q[2] <= LEVEL_POS;
            map_q_q[2] <= LEVEL_NEG;
            map_i_q[3] <= LEVEL_NEG;
            map_q_q[3] <= LEVEL_NEG;
            ptr_q       <= PTR_RST;
            prev_bit_q  <= 1'b0;
            have_prev_q <= 1'b0;
            acc_q       <= '0;
            acc_cnt_q   <= '0;
            out_valid_q <= 1'b0;
            out_state_q <= '0;
            out_i_q     <= '0;
            out_q_q     <= '0;
            bps_q       <= 4'h2;
        end else begin
            ofs_tab_q   <= ofs_tab_d;
            map_i_q     <= map_i_d;
            map_q_q     <= map_q_d;
            ptr_q       <= ptr_d;
            prev_bit_q  <= prev_bit_d;
            have_prev_q <= have_prev_d;
            acc_q       <= acc_d;
            acc_cnt_q   <= acc_cnt_d;
            out_valid_q <= out_valid_d;
            out_state_q <= out_state_d;
            out_i_q     <= out_i_d;
            out_q_q     <= out_q_d;
            bps_q       <= bps_d;
        end
    end

    assign out_valid       = out_valid_q;
    assign out_state       = out_state_q;
    assign out_i           = out_i_q;
    assign out_q           = out_q_q;
    assign bits_per_symbol = bps_q;

endmodule

`default_nettype wire

// [dv/differential_symbol_encoder_assertions.sv]
// Port checks for the differential symbol encoder
`timescale 1ns/1ps
`default_nettype none
module dse_checker import diff_enc_pkg::*; (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire enc_mode_t enc_mode,
    input wire logic [NST_W-1:0] num_states,
    input wire logic enc_restart,
    input wire logic ofs_wr,
    input wire logic [DATA_W-1:0] ofs_addr,
    input wire logic signed [OFS_W-1:0] ofs_val,
    input wire logic map_wr,
    input wire logic [DATA_W-1:0] map_addr,
    input wire logic [IQ_W-1:0] map_i,
    input wire logic [IQ_W-1:0] map_q,
    input wire logic in_valid,
    input wire logic [DATA_W-1:0] in_data,
    input wire logic out_valid,
    input wire logic [DATA_W-1:0] out_state,
    input wire logic [IQ_W-1:0] out_i,
    input wire logic [IQ_W-1:0] out_q,
    input wire logic [CNT_W-1:0] bits_per_symbol
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    wire logic tk = in_valid && !enc_restart;
    take_answer_a: assert property (tk && enc_mode != ENC_DIFF_DATA && enc_mode != 2'h3
        |=> out_valid) else $error("no symbol after take");
    no_spurious_a: assert property (out_valid |-> $past(tk))
        else $error("symbol without take");
    dead_mode_a: assert property (tk && enc_mode == 2'h3 |=> !out_valid)
        else $error("symbol in unused mode");
    plain_pass_a: assert property (tk && enc_mode == ENC_OFF && in_data < num_states
        |=> out_state == $past(in_data)) else $error("plain mode moved");
    state_hold_a: assert property (!out_valid |-> $stable(out_state))
        else $error("state moved without symbol");
    bps_value_a: assert property ($stable(num_states) && $past(arst_n) |->
        bits_per_symbol == (num_states < 9'h002 ? 4'h1 : 4'($clog2(num_states))))
        else $error("bits per symbol wrong");
    diff_first_a: assert property (enc_restart ##1 (tk && enc_mode == ENC_DIFF_DATA)
        |=> !out_valid) else $error("first raw bit gave output");
    ptr_wrap_a: assert property (out_valid && $past(enc_mode) == ENC_SYMBOL_OFFSET
        |-> out_state < $past(num_states) || out_state == 8'h00) else $error("pointer out of map");
    cover property (tk && enc_mode == ENC_DIFF_DATA ##1 out_valid);
    cover property (tk [*3] ##1 out_valid);
    cover property (enc_restart ##1 tk);
endmodule
bind differential_symbol_encoder dse_checker chk_u (.sys_clk(sys_clk), .arst_n(arst_n),
    .enc_mode(enc_mode), .num_states(num_states), .enc_restart(enc_restart),
    .ofs_wr(ofs_wr), .ofs_addr(ofs_addr), .ofs_val(ofs_val), .map_wr(map_wr),
    .map_addr(map_addr), .map_i(map_i), .map_q(map_q), .in_valid(in_valid),
    .in_data(in_data), .out_valid(out_valid), .out_state(out_state), .out_i(out_i),
    .out_q(out_q), .bits_per_symbol(bits_per_symbol));
`default_nettype wire

// [dv/iq_sink_model.sv]
// Downstream I/Q mapper stand-in that counts delivered symbols
`timescale 1ns/1ps
`default_nettype none
module iq_sink_model (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic sym_valid,
    output logic [15:0] rx_count
);
    // No backpressure downstream, so every pulse is one symbol consumed
    always_ff @(posedge sys_clk or negedge arst_n)
        if (!arst_n) rx_count <= 16'h0000;
        else if (sym_valid) rx_count <= rx_count + 16'h0001;
endmodule
`default_nettype wire

// [dv/differential_symbol_encoder_tb_top.sv]
// Self-checking bench for the differential symbol encoder
`timescale 1ns/1ps
`default_nettype none
module differential_symbol_encoder_tb_top import diff_enc_pkg::*;;
    logic sys_clk = 1'h0, arst_n = 1'h0, enc_restart = 1'h0, ofs_wr = 1'h0, map_wr = 1'h0;
    logic in_valid = 1'h0, out_valid, b, pv;
    enc_mode_t enc_mode = ENC_OFF;
    logic [NST_W-1:0] num_states = 9'h004;
    logic [DATA_W-1:0] ofs_addr = 8'h00, map_addr = 8'h00, in_data = 8'h00, out_state, s;
    logic signed [OFS_W-1:0] ofs_val = 8'h00;
    logic [IQ_W-1:0] map_i = 16'h0000, map_q = 16'h0000, out_i, out_q;
    logic [CNT_W-1:0] bits_per_symbol;
    logic [15:0] rx_count;
    logic [12:0] acc;
    logic signed [7:0] ot [256];
    int bad_count = 0, check_count = 0, cyc = 0, seed = 57, exp_n = 0, p, n;
    differential_symbol_encoder dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .enc_mode(enc_mode),
        .num_states(num_states), .enc_restart(enc_restart), .ofs_wr(ofs_wr),
        .ofs_addr(ofs_addr), .ofs_val(ofs_val), .map_wr(map_wr), .map_addr(map_addr),
        .map_i(map_i), .map_q(map_q), .in_valid(in_valid), .in_data(in_data),
        .out_valid(out_valid), .out_state(out_state), .out_i(out_i), .out_q(out_q),
        .bits_per_symbol(bits_per_symbol));
    iq_sink_model sink_u (.sys_clk(sys_clk), .arst_n(arst_n), .sym_valid(out_valid),
        .rx_count(rx_count));
    initial forever #4 sys_clk = ~sys_clk;
    task test_done;
        if (bad_count == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            test_done;
        end
    end
    task chk(input logic [15:0] sv, ev);
        check_count++;
        if (sv !== ev) begin
            bad_count++;
            $display("mismatch %0t seen %h expected %h", $time, sv, ev);
        end
    endtask
    // Inputs stay applied until the next call, so calls run back to back
    task step(input logic v, input logic [7:0] x, input logic ev, input logic [7:0] es);
        in_valid = v;
        in_data = x;
        @(posedge sys_clk) #1;
        chk(out_valid, ev);
        if (ev) chk(out_state, es);
        exp_n += ev;
    endtask
    task wr(input logic [7:0] a, input logic signed [7:0] v, input logic [15:0] i, q);
        {ofs_wr, map_wr, ofs_addr, map_addr, ofs_val, map_i, map_q} = {2'h3, a, a, v, i, q};
        @(posedge sys_clk) #1;
    endtask
    task restart;
        enc_restart = 1'h1;
        @(posedge sys_clk) #1;
        enc_restart = 1'h0;
    endtask
    function automatic int nxt(int q, int o, int m);
        return ((q + o) % m + m) % m;
    endfunction
    // Bits per symbol: ceiling of log2 of the state count, never below one
    function automatic logic [3:0] exp_bps(int m);
        int w;
        w = 1;
        while ((1 << w) < m) w++;
        return 4'(w);
    endfunction
    initial begin
        repeat (2) @(posedge sys_clk);
        #1 arst_n = 1'h1;
        chk(bits_per_symbol, 4'h2);
        for (int k = 0; k < 4; k++) begin
            step(1'h1, k[7:0], 1'h1, k[7:0]);
            chk(out_i, k[0] ? LEVEL_NEG : LEVEL_POS);
            chk(out_q, k[1] ? LEVEL_NEG : LEVEL_POS);
        end
        enc_mode = enc_mode_t'(2'h3);
        step(1'h1, 8'h01, 1'h0, 8'h00);
        for (int k = 0; k < 4; k++) begin
            ot[k] = k == 0 ? 1 : k == 1 ? -1 : k == 2 ? 2 : 0;
            wr(k[7:0], ot[k], k[0] ? LEVEL_NEG : LEVEL_POS, k[1] ? LEVEL_NEG : LEVEL_POS);
        end
        {ofs_wr, map_wr} = 2'h0;
        enc_mode = ENC_SYMBOL_OFFSET;
        restart;
        p = 0;
        for (int j = 0; j < 5; j++) begin
            s = 8'((10'h0e1 >> (8 - 2 * j)) & 10'h003);
            p = nxt(p, ot[s], 4);
            step(1'h1, s, 1'h1, p[7:0]);
        end
        num_states = 9'h000;
        step(1'h0, 8'h00, 1'h0, 8'h00);
        chk(bits_per_symbol, exp_bps(0));
        num_states = 9'h002;
        step(1'h0, 8'h00, 1'h0, 8'h00);
        chk(bits_per_symbol, 4'h1);
        enc_mode = ENC_DIFF_DATA;
        restart;
        for (int j = 0; j < 14; j++) begin
            b = 1'(14'h14ca >> (13 - j));
            step(1'h1, {7'h00, b}, j > 0, {7'h00, b ^ pv});
            acc = {acc[11:0], out_state[0]};
            pv = b;
        end
        step(1'h0, 8'h00, 1'h0, 8'h00);
        chk(acc, 13'h1eaf);
        // Two-bit groups: encoded bits pair up first-bit-high into each symbol
        num_states = 9'h004;
        restart;
        for (int j = 0; j < 14; j++) begin
            b = 1'(14'h14ca >> (13 - j));
            step(1'h1, {7'h00, b}, j > 1 && j % 2 == 0,
                 8'((13'h1eaf >> (13 - j)) & 13'h0003));
        end
        step(1'h0, 8'h00, 1'h0, 8'h00);
        for (int r = 0; r < 3; r++) begin
            n = ($random(seed) & 255) + 1;
            num_states = n[8:0];
            for (int k = 0; k < n; k++) begin
                ot[k] = 8'($random(seed));
                wr(k[7:0], ot[k], {~k[7:0], k[7:0]}, {k[7:0], 8'h3c});
            end
            {ofs_wr, map_wr} = 2'h0;
            chk(bits_per_symbol, exp_bps(n));
            enc_mode = ENC_SYMBOL_OFFSET;
            restart;
            p = 0;
            repeat (40) begin
                s = 8'(($random(seed) & 255) % n);
                p = nxt(p, ot[s], n);
                step(1'h1, s, 1'h1, p[7:0]);
                chk(out_i, {~p[7:0], p[7:0]});
                chk(out_q, {p[7:0], 8'h3c});
            end
            step(1'h0, 8'h00, 1'h0, 8'h00);
        end
        chk(rx_count, exp_n[15:0]);
        test_done;
    end
endmodule
`default_nettype wire
